// ==== phy_irq_pkg.sv ====
package phy_irq_pkg;
   localparam int         ADDR_W          = 12;
   localparam logic [11:0] OFS_ENABLE     = 12'h110;
   localparam logic [11:0] OFS_DISABLE    = 12'h114;
   localparam logic [11:0] OFS_MASK_VIEW  = 12'h118;
   localparam logic [11:0] OFS_PENDING    = 12'h11c;
   localparam logic [31:0] EVENT_BITS     = 32'hc00000ff;
   localparam logic [31:0] MASK_RESET     = 32'h00000000;
   localparam logic [31:0] PENDING_RESET  = 32'h00000000;
   localparam int         BIT_TX_RESET    = 0;
   localparam int         BIT_RX_RESET    = 1;
   localparam int         BIT_CH_PLL      = 2;
   localparam int         BIT_QUAD_PLL_ZERO   = 3;
   localparam int         BIT_TX_ALIGN    = 4;
   localparam int         BIT_QUAD_PLL_ONE    = 5;
   localparam int         BIT_TX_FREQ     = 6;
   localparam int         BIT_RX_FREQ     = 7;
   localparam int         BIT_TX_DEBOUNCE = 30;
   localparam int         BIT_RX_DEBOUNCE = 31;
   localparam logic [1:0] RESP_OKAY       = 2'h0;
   localparam logic [1:0] RESP_SLVERR     = 2'h2;
endpackage : phy_irq_pkg

// ==== level_change_detect.sv ====
`timescale 1ns/1ps
// Flags every change, rising or falling, of a group of levels. The first
// sample after reset is only taken as the reference, so a level that is
// already high when reset releases raises no event.
module level_change_detect #(
   parameter int WIDTH = 4
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rstSyncN,
   // Levels and their change pulses
   input  wire logic [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] changed
);
   typedef struct packed {
      logic [WIDTH-1:0] last;
      logic             primed;
   } state_t;

   state_t cur;
   state_t next_cur;

   initial begin
      if (WIDTH < 1) $error("WIDTH must be at least one");
   end

   always_comb begin
      next_cur        = cur;
      next_cur.last   = level;
      next_cur.primed = 1'b1;
   end

   assign changed = cur.primed ? (level ^ cur.last) : '0;

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end
endmodule : level_change_detect

// ==== phy_event_interrupt_ctrl.sv ====
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module phy_event_interrupt_ctrl (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // AXI4-Lite write address
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Event levels from the transceiver status
   input  wire logic        txResetDone,
   input  wire logic        rxResetDone,
   input  wire logic        channelPllLock,
   input  wire logic        pllZeroLock,
   input  wire logic        pllOneLock,
   // Event pulses from alignment and clock detector
   input  wire logic        txAlignDone,
   input  wire logic        txFreqChange,
   input  wire logic        rxFreqChange,
   input  wire logic        txDebounceTimeout,
   input  wire logic        rxDebounceTimeout,
   // Interrupt
   output logic             irq
);
   typedef struct packed {
      logic        awHeld;
      logic [11:0] awAddr;
      logic        wHeld;
      logic [31:0] wData;
      logic [3:0]  wStrb;
      logic        bValid;
      logic [1:0]  bResp;
      logic        rValid;
      logic [31:0] rData;
      logic [1:0]  rResp;
      logic [31:0] maskView;
      logic [31:0] pending;
      logic        irq;
   } state_t;

   state_t     cur;
   state_t     next_cur;
   logic [1:0] rstPipe;
   logic       rstSyncN;
   logic [4:0] levelChanged;
   logic [31:0] eventHits;
   logic [31:0] wrBits;
   logic        wrFire;
   logic        rdFire;

   // Combinational word offset, so a narrow address bus cannot alias by accident.
   function automatic logic [11:0] wordAddr(input logic [11:0] a);
      wordAddr = {a[11:2], 2'b00};
   endfunction : wordAddr

   function automatic logic isMapped(input logic [11:0] a);
      isMapped = (wordAddr(a) == phy_irq_pkg::OFS_ENABLE)    ||
                 (wordAddr(a) == phy_irq_pkg::OFS_DISABLE)   ||
                 (wordAddr(a) == phy_irq_pkg::OFS_MASK_VIEW) ||
                 (wordAddr(a) == phy_irq_pkg::OFS_PENDING);
   endfunction : isMapped

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstPipe <= 2'b00;
      end else begin
         rstPipe <= {rstPipe[0], 1'b1};
      end
   end
   assign rstSyncN = rstPipe[1];

   // Reset-done and lock levels signal every edge, hence change detection.
   level_change_detect #(
      .WIDTH (5)
   ) u_change (
      .clk      (clk),
      .rstSyncN (rstSyncN),
      .level    ({pllOneLock, pllZeroLock, channelPllLock, rxResetDone, txResetDone}),
      .changed  (levelChanged)
   );

   always_comb begin
      eventHits = '0;
      eventHits[phy_irq_pkg::BIT_TX_RESET]    = levelChanged[0];
      eventHits[phy_irq_pkg::BIT_RX_RESET]    = levelChanged[1];
      eventHits[phy_irq_pkg::BIT_CH_PLL]      = levelChanged[2];
      eventHits[phy_irq_pkg::BIT_QUAD_PLL_ZERO]   = levelChanged[3];
      eventHits[phy_irq_pkg::BIT_QUAD_PLL_ONE]    = levelChanged[4];
      eventHits[phy_irq_pkg::BIT_TX_ALIGN]    = txAlignDone;
      eventHits[phy_irq_pkg::BIT_TX_FREQ]     = txFreqChange;
      eventHits[phy_irq_pkg::BIT_RX_FREQ]     = rxFreqChange;
      eventHits[phy_irq_pkg::BIT_TX_DEBOUNCE] = txDebounceTimeout;
      eventHits[phy_irq_pkg::BIT_RX_DEBOUNCE] = rxDebounceTimeout;
   end

   assign s_axi_awready = !cur.awHeld;
   assign s_axi_wready  = !cur.wHeld;
   assign s_axi_arready = !cur.rValid;
   assign s_axi_bvalid  = cur.bValid;
   assign s_axi_bresp   = cur.bResp;
   assign s_axi_rvalid  = cur.rValid;
   assign s_axi_rdata   = cur.rData;
   assign s_axi_rresp   = cur.rResp;
   assign irq           = cur.irq;

   // A write commits once address and data are both held and no response waits.
   assign wrFire = cur.awHeld && cur.wHeld && !cur.bValid;
   assign rdFire = s_axi_arvalid && !cur.rValid;
   // Partial byte strobes only touch the lanes they enable.
   assign wrBits = cur.wData & {{8{cur.wStrb[3]}}, {8{cur.wStrb[2]}},
                                {8{cur.wStrb[1]}}, {8{cur.wStrb[0]}}} & phy_irq_pkg::EVENT_BITS;

   always_comb begin
      next_cur = cur;
      if (s_axi_awvalid && !cur.awHeld) begin
         next_cur.awHeld = 1'b1;
         next_cur.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !cur.wHeld) begin
         next_cur.wHeld = 1'b1;
         next_cur.wData = s_axi_wdata;
         next_cur.wStrb = s_axi_wstrb;
      end
      if (cur.bValid && s_axi_bready) begin
         next_cur.bValid = 1'b0;
      end
      if (cur.rValid && s_axi_rready) begin
         next_cur.rValid = 1'b0;
      end
      if (wrFire) begin
         next_cur.awHeld = 1'b0;
         next_cur.wHeld  = 1'b0;
         next_cur.bValid = 1'b1;
         next_cur.bResp  = isMapped(cur.awAddr) ? phy_irq_pkg::RESP_OKAY : phy_irq_pkg::RESP_SLVERR;
         unique case (wordAddr(cur.awAddr))
            phy_irq_pkg::OFS_ENABLE: begin
               next_cur.maskView = cur.maskView | wrBits;
            end
            phy_irq_pkg::OFS_DISABLE: begin
               next_cur.maskView = cur.maskView & ~wrBits;
            end
            phy_irq_pkg::OFS_PENDING: begin
               next_cur.pending = cur.pending & ~wrBits;
            end
            default: begin
            end
         endcase
      end
      // Events are applied after the clear so an event in the clearing cycle survives.
      next_cur.pending = (next_cur.pending | eventHits) & phy_irq_pkg::EVENT_BITS;
      if (rdFire) begin
         next_cur.rValid = 1'b1;
         next_cur.rResp  = isMapped(s_axi_araddr) ? phy_irq_pkg::RESP_OKAY : phy_irq_pkg::RESP_SLVERR;
         unique case (wordAddr(s_axi_araddr))
            phy_irq_pkg::OFS_MASK_VIEW: next_cur.rData = cur.maskView;
            phy_irq_pkg::OFS_PENDING:   next_cur.rData = cur.pending;
            default:                    next_cur.rData = 32'h00000000;
         endcase
      end
      next_cur.irq = |(next_cur.pending & next_cur.maskView);
   end

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         cur          <= '0;
         cur.maskView <= phy_irq_pkg::MASK_RESET;
         cur.pending  <= phy_irq_pkg::PENDING_RESET;
      end else begin
         cur <= next_cur;
      end
   end
endmodule : phy_event_interrupt_ctrl

// ==== phy_event_interrupt_ctrl_chk.sv ====
`timescale 1ns/1ps
module phy_event_interrupt_ctrl_chk (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // Read channels
   input wire logic [11:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Write response and interrupt
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        irq
);
   logic [11:0] readAddr;
   // The address leaves the bus once taken, so it is kept for the data beat.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) readAddr <= 12'h000;
      else if (s_axi_arvalid && s_axi_arready) readAddr <= s_axi_araddr;
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   property p_rsv_zero; s_axi_rvalid |-> s_axi_rdata[29:8] == 22'h000000; endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("unused bits read nonzero");
   property p_dis_zero; s_axi_rvalid && readAddr == 12'h114 |-> s_axi_rdata == 32'h00000000; endproperty
   a_dis_zero: assert property (p_dis_zero) else $error("disable port read back data");
   property p_mask_bits; s_axi_rvalid && readAddr == 12'h118 |-> (s_axi_rdata & 32'h3fffff00) == 32'h00000000; endproperty
   a_mask_bits: assert property (p_mask_bits) else $error("mask view shows a non-event bit");
   property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data dropped before taken");
   property p_wr_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write response dropped before taken");
   property p_irq_fall; $fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without a write");
   property p_unmapped; s_axi_rvalid && readAddr[11:4] != 8'h11 |-> s_axi_rresp == 2'h2; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
endmodule : phy_event_interrupt_ctrl_chk

bind phy_event_interrupt_ctrl phy_event_interrupt_ctrl_chk u_chk (
   .clk(clk), .rst_n(rst_n), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .irq(irq)
);

// ==== phy_event_interrupt_ctrl_test.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module phy_event_interrupt_ctrl_test;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h00000000;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic [9:0]  evt = 10'h000;
   logic [3:0]  strb = 4'hf;
   logic [1:0]  bresp, rresp, rr;
   logic [31:0] rdata, rd;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   int          err_count = 0;
   int          n_checks = 0;
   int          bitOf [10] = '{0, 1, 2, 3, 5, 4, 6, 7, 30, 31};
   always #5 clk = ~clk;
   phy_event_interrupt_ctrl DUT (
      .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .txResetDone(evt[0]), .rxResetDone(evt[1]),
      .channelPllLock(evt[2]), .pllZeroLock(evt[3]), .pllOneLock(evt[4]), .txAlignDone(evt[5]),
      .txFreqChange(evt[6]), .rxFreqChange(evt[7]), .txDebounceTimeout(evt[8]),
      .rxDebounceTimeout(evt[9]), .irq(irq)
   );
   // Ready is raised late on purpose so the slave must hold its answer.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b1;
      @(posedge clk);
      bready <= 1'b0;
      `CHK("bresp", 2'h0, bresp)
   endtask : wr
   task automatic rdr(input logic [11:0] a);
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b1;
      @(posedge clk);
      rready <= 1'b0;
      rd = rdata;
      rr = rresp;
   endtask : rdr
   task automatic chkrd(input string nm, input logic [11:0] a, input logic [31:0] e);
      rdr(a);
      `CHK(nm, e, rd)
   endtask : chkrd
   task automatic t_reset_values;
      chkrd("mask", phy_irq_pkg::OFS_MASK_VIEW, 32'h00000000);
      chkrd("pend", phy_irq_pkg::OFS_PENDING, 32'h00000000);
      chkrd("dis", phy_irq_pkg::OFS_DISABLE, 32'h00000000);
      rdr(12'h200);
      `CHK("unmapped", phy_irq_pkg::RESP_SLVERR, rr)
   endtask : t_reset_values
   // Levels are toggled twice so both directions of change are seen.
   task automatic t_each_event;
      int k;
      wr(phy_irq_pkg::OFS_ENABLE, 32'hffffffff);
      chkrd("mask", phy_irq_pkg::OFS_MASK_VIEW, phy_irq_pkg::EVENT_BITS);
      for (int i = 0; i < 15; i++) begin
         k = i % 10;
         @(posedge clk);
         evt[k] <= ~evt[k];
         @(posedge clk);
         if (k > 4) evt[k] <= 1'b0;
         repeat (3) @(posedge clk);
         `CHK("irq", 1'b1, irq)
         chkrd("pend", phy_irq_pkg::OFS_PENDING, 32'h1 << bitOf[k]);
         wr(phy_irq_pkg::OFS_PENDING, 32'h1 << bitOf[k]);
         chkrd("pend", phy_irq_pkg::OFS_PENDING, 32'h00000000);
         `CHK("irq", 1'b0, irq)
      end
   endtask : t_each_event
   task automatic t_mask_gate;
      wr(phy_irq_pkg::OFS_DISABLE, 32'h00000001);
      wr(phy_irq_pkg::OFS_MASK_VIEW, 32'h00000000);
      chkrd("mask", phy_irq_pkg::OFS_MASK_VIEW, phy_irq_pkg::EVENT_BITS & ~32'h1);
      @(posedge clk);
      evt[0] <= ~evt[0];
      repeat (3) @(posedge clk);
      `CHK("irq", 1'b0, irq)
      wr(phy_irq_pkg::OFS_PENDING, 32'h00000000);
      chkrd("pend", phy_irq_pkg::OFS_PENDING, 32'h00000001);
      wr(phy_irq_pkg::OFS_ENABLE, 32'h3fffff00);
      chkrd("mask", phy_irq_pkg::OFS_MASK_VIEW, phy_irq_pkg::EVENT_BITS & ~32'h1);
      wr(phy_irq_pkg::OFS_ENABLE, 32'h00000001);
      `CHK("irq", 1'b1, irq)
      // A write whose byte lanes are all off must leave the mask alone.
      @(posedge clk);
      strb <= 4'h0;
      wr(phy_irq_pkg::OFS_DISABLE, 32'h00000001);
      chkrd("mask", phy_irq_pkg::OFS_MASK_VIEW, phy_irq_pkg::EVENT_BITS);
      `CHK("irq", 1'b1, irq)
      @(posedge clk);
      strb <= 4'hf;
   endtask : t_mask_gate
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset_values();
      t_each_event();
      t_mask_gate();
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      tally_and_finish();
   end
endmodule : phy_event_interrupt_ctrl_test
